/* rtl/rqc_config.sv */
// reference input qualify configuration registers and per-reference front ends
// assumes a byte-wide host register port synchronous to clk_i, 25 MHz
//
// Behaviour
// - a set halving bit divides that reference clock by two before the PLL
// - set type bit selects differential pins; clear uses positive pin only
// - reference drops a coded delay after coarse frequency or single cycle flag
// - reference returns after both flags clear for 2,4,6 or 8 drop delays
// - delay registers hold four 2-bit fields, reference 0 in the lowest bits
// - writing 0x01 to the lock register freezes sticky status updates
// - writing 0x00 to the lock register resumes sticky status updates
// - any other base rate code acts as 8 kHz
// - multi-byte registers are big-endian: high byte at the lower address
// - qualify timers act on coarse frequency and single cycle fail flags
`default_nettype none
module rqc_config
  import rqc_pkg::*;
#(
  parameter int unsigned DROP_10MS_CYC = RQC_DROP_10MS_US * RQC_CLK_MHZ,
  parameter int unsigned DROP_50MS_CYC = RQC_DROP_50MS_US * RQC_CLK_MHZ,
  parameter int unsigned DROP_2S5_CYC  = RQC_DROP_2S5_US * RQC_CLK_MHZ
) (
  // clock and reset
  input  wire logic                clk_i,
  input  wire logic                arst_n_i,
  // host register port
  input  wire rqc_req_t            reg_req_i,
  output logic [7:0]               reg_rdata_o,
  // reference pins
  input  wire logic [RQC_NREF-1:0] ref_p_i,
  input  wire logic [RQC_NREF-1:0] ref_n_i,
  // monitor flags
  input  wire logic [RQC_NREF-1:0] cfm_fail_i,
  input  wire logic [RQC_NREF-1:0] scm_fail_i,
  // results
  output logic [RQC_NREF-1:0]      ref_pll_o,
  output logic [RQC_NREF-1:0]      ref_qualified_o,
  output logic                     sticky_update_en_o,
  output logic [15:0]              base_rate_hz_o
);

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] setup;
    logic [7:0] drop;
    logic [7:0] accept;
    logic [7:0] lock;
    logic [7:0] base_hi;
    logic [7:0] base_lo;
    logic [7:0] rdata;
  } rqc_regs_t;

  localparam rqc_regs_t RQC_REGS_RST = '{
    setup:   RQC_RST_SETUP,
    drop:    RQC_RST_DROP,
    accept:  RQC_RST_ACCEPT,
    lock:    RQC_RST_LOCK,
    base_hi: RQC_RST_BASE[15:8],
    base_lo: RQC_RST_BASE[7:0],
    rdata:   8'h00
  };

  rqc_regs_t        r_q, r_d;
  logic [15:0]      base_raw;
  logic             base_ok;
  logic [1:0]       drop_code  [RQC_NREF];
  logic [1:0]       accept_code[RQC_NREF];

  // ----------------------------------------------------------------
  // register access
  // ----------------------------------------------------------------

  // byte writes and registered read data
  always_comb begin
    r_d = r_q;
    if (reg_req_i.wr) begin
      case (reg_req_i.addr)
        RQC_ADDR_SETUP:   r_d.setup   = reg_req_i.wdata;
        RQC_ADDR_DROP:    r_d.drop    = reg_req_i.wdata;
        RQC_ADDR_ACCEPT:  r_d.accept  = reg_req_i.wdata;
        RQC_ADDR_LOCK:    r_d.lock    = reg_req_i.wdata;
        RQC_ADDR_BASE_HI: r_d.base_hi = reg_req_i.wdata;
        RQC_ADDR_BASE_LO: r_d.base_lo = reg_req_i.wdata;
        default:          r_d.lock    = r_q.lock;          // unmapped or read-only
      endcase
    end
    if (reg_req_i.rd) begin
      case (reg_req_i.addr)
        RQC_ADDR_SETUP:   r_d.rdata = r_q.setup;
        RQC_ADDR_DROP:    r_d.rdata = r_q.drop;
        RQC_ADDR_ACCEPT:  r_d.rdata = r_q.accept;
        RQC_ADDR_LOCK:    r_d.rdata = r_q.lock;
        RQC_ADDR_STATUS:  r_d.rdata = {3'h0, ~sticky_update_en_o, ref_qualified_o};
        RQC_ADDR_BASE_HI: r_d.rdata = r_q.base_hi;
        RQC_ADDR_BASE_LO: r_d.rdata = r_q.base_lo;
        default:          r_d.rdata = 8'h00;
      endcase
    end
  end

  // register bank
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      r_q <= RQC_REGS_RST;
    end else begin
      r_q <= r_d;
    end
  end

  assign reg_rdata_o = r_q.rdata;

  // ----------------------------------------------------------------
  // derived controls
  // ----------------------------------------------------------------

  // sticky status freezes only while the lock holds the lock code
  assign sticky_update_en_o = (r_q.lock != RQC_LOCK_ON);

  // out-of-set base rate codes fall back to 8 kHz
  assign base_raw = {r_q.base_hi, r_q.base_lo};
  assign base_ok  = (base_raw == RQC_BASE_8K)  || (base_raw == RQC_BASE_16K) ||
                    (base_raw == RQC_BASE_25K) || (base_raw == RQC_BASE_40K);
  assign base_rate_hz_o = base_ok ? base_raw : RQC_BASE_8K;

  // ----------------------------------------------------------------
  // per-reference front ends
  // ----------------------------------------------------------------
  for (genvar i = 0; i < RQC_NREF; i++) begin : g_ref
    assign drop_code[i]   = r_q.drop[RQC_CODE_W*i +: RQC_CODE_W];
    assign accept_code[i] = r_q.accept[RQC_CODE_W*i +: RQC_CODE_W];

    rqc_ref_qualify #(
      .DROP_10MS_CYC (DROP_10MS_CYC),
      .DROP_50MS_CYC (DROP_50MS_CYC),
      .DROP_2S5_CYC  (DROP_2S5_CYC)
    ) u_ref (
      .clk_i         (clk_i),
      .arst_n_i      (arst_n_i),
      .ref_p_i       (ref_p_i[i]),
      .ref_n_i       (ref_n_i[i]),
      .cfm_fail_i    (cfm_fail_i[i]),
      .scm_fail_i    (scm_fail_i[i]),
      .halve_i       (r_q.setup[RQC_HALVE_LSB + i]),
      .diff_i        (r_q.setup[RQC_TYPE_LSB + i]),
      .drop_code_i   (drop_code[i]),
      .accept_code_i (accept_code[i]),
      .ref_pll_o     (ref_pll_o[i]),
      .qualified_o   (ref_qualified_o[i])
    );
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  sequence s_wr(logic [7:0] a, logic [7:0] v);
    reg_req_i.wr && reg_req_i.addr == a && reg_req_i.wdata == v;
  endsequence

  a_lock_freeze: assert property (s_wr(RQC_ADDR_LOCK, RQC_LOCK_ON) |=> !sticky_update_en_o)
    else $error("lock code did not freeze sticky updates");
  a_lock_release: assert property (s_wr(RQC_ADDR_LOCK, RQC_LOCK_OFF) |=> sticky_update_en_o)
    else $error("unlock code did not resume sticky updates");
  a_lock_hold: assert property (!sticky_update_en_o && !(reg_req_i.wr &&
                 reg_req_i.addr == RQC_ADDR_LOCK) |=> !sticky_update_en_o)
    else $error("sticky freeze released without a lock write");
  a_base_legal: assert property (base_rate_hz_o == RQC_BASE_8K || base_rate_hz_o == RQC_BASE_16K ||
                 base_rate_hz_o == RQC_BASE_25K || base_rate_hz_o == RQC_BASE_40K)
    else $error("base rate output outside the permitted set");
  a_base_fallback: assert property (!base_ok |-> base_rate_hz_o == RQC_BASE_8K)
    else $error("invalid base rate did not fall back to 8 kHz");
  a_big_endian: assert property (reg_req_i.wr && reg_req_i.addr == RQC_ADDR_BASE_HI
                 ##1 reg_req_i.wr && reg_req_i.addr == RQC_ADDR_BASE_LO
                 |=> base_raw == {$past(reg_req_i.wdata, 2), $past(reg_req_i.wdata)})
    else $error("base rate bytes not assembled high byte first");
  a_field_pack: assert property (reg_req_i.wr && reg_req_i.addr == RQC_ADDR_DROP
                 |=> drop_code[3] == $past(reg_req_i.wdata[7:6]) &&
                     drop_code[0] == $past(reg_req_i.wdata[1:0]))
    else $error("drop delay fields not packed per reference");
  a_read_back: assert property (reg_req_i.rd && reg_req_i.addr == RQC_ADDR_SETUP
                 && !reg_req_i.wr |=> reg_rdata_o == r_q.setup)
    else $error("setup register read-back mismatch");

  c_lock: cover property (s_wr(RQC_ADDR_LOCK, RQC_LOCK_ON) ##1 s_wr(RQC_ADDR_LOCK, RQC_LOCK_OFF));
  c_bad_base: cover property (!base_ok);
  c_halving: cover property (r_q.setup[RQC_HALVE_LSB] && $rose(ref_pll_o[0]));

endmodule
`default_nettype wire

/* rtl/rqc_pkg.sv */
// reference input qualify configuration: shared constants and types
// assumes byte-wide register accesses synchronous to the 25 MHz clock
`default_nettype none
package rqc_pkg;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] RQC_ADDR_SETUP   = 8'h0a;
  localparam logic [7:0] RQC_ADDR_DROP    = 8'h0b;
  localparam logic [7:0] RQC_ADDR_ACCEPT  = 8'h0c;
  localparam logic [7:0] RQC_ADDR_LOCK    = 8'h0d;
  localparam logic [7:0] RQC_ADDR_STATUS  = 8'h0e;
  localparam logic [7:0] RQC_ADDR_BASE_HI = 8'h10;
  localparam logic [7:0] RQC_ADDR_BASE_LO = 8'h11;

  // ----------------------------------------------------------------
  // reset values and field layout
  // ----------------------------------------------------------------
  localparam logic [7:0]  RQC_RST_SETUP   = 8'h10;
  localparam logic [7:0]  RQC_RST_DROP    = 8'haa;
  localparam logic [7:0]  RQC_RST_ACCEPT  = 8'h55;
  localparam logic [7:0]  RQC_RST_LOCK    = 8'h00;
  localparam logic [15:0] RQC_RST_BASE    = 16'h9c40;
  localparam int          RQC_NREF        = 4;
  localparam int          RQC_HALVE_LSB   = 0;
  localparam int          RQC_TYPE_LSB    = 4;
  localparam int          RQC_CODE_W      = 2;
  localparam logic [7:0]  RQC_LOCK_ON     = 8'h01;
  localparam logic [7:0]  RQC_LOCK_OFF    = 8'h00;

  // ----------------------------------------------------------------
  // permitted base rates in hertz
  // ----------------------------------------------------------------
  localparam logic [15:0] RQC_BASE_8K     = 16'h1f40;
  localparam logic [15:0] RQC_BASE_16K    = 16'h3e80;
  localparam logic [15:0] RQC_BASE_25K    = 16'h61a8;
  localparam logic [15:0] RQC_BASE_40K    = 16'h9c40;

  // ----------------------------------------------------------------
  // timing: clock rate and drop delays in microseconds
  // ----------------------------------------------------------------
  localparam int unsigned RQC_CLK_MHZ     = 25;
  localparam int unsigned RQC_DROP_MIN_CYC = 1;
  localparam int unsigned RQC_DROP_10MS_US = 10000;
  localparam int unsigned RQC_DROP_50MS_US = 50000;
  localparam int unsigned RQC_DROP_2S5_US  = 2500000;
  localparam int unsigned RQC_CNT_W       = 32;

  // host register request carrier
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rqc_req_t;

  // one-hot qualifier states
  typedef enum logic [3:0] {
    RQC_ST_QUAL = 4'h1,
    RQC_ST_DROP = 4'h2,
    RQC_ST_DISQ = 4'h4,
    RQC_ST_ACC  = 4'h8
  } rqc_qstate_t;

endpackage
`default_nettype wire

/* rtl/rqc_ref_qualify.sv */
// one reference input: receiver type, halving stage and qualify timers
// assumes pins and monitor flags are synchronous to clk_i
`default_nettype none
module rqc_ref_qualify
  import rqc_pkg::*;
#(
  parameter int unsigned DROP_10MS_CYC = RQC_DROP_10MS_US * RQC_CLK_MHZ,
  parameter int unsigned DROP_50MS_CYC = RQC_DROP_50MS_US * RQC_CLK_MHZ,
  parameter int unsigned DROP_2S5_CYC  = RQC_DROP_2S5_US * RQC_CLK_MHZ
) (
  // clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  arst_n_i,
  // pins and monitor flags
  input  wire logic                  ref_p_i,
  input  wire logic                  ref_n_i,
  input  wire logic                  cfm_fail_i,
  input  wire logic                  scm_fail_i,
  // configuration
  input  wire logic                  halve_i,
  input  wire logic                  diff_i,
  input  wire logic [RQC_CODE_W-1:0] drop_code_i,
  input  wire logic [RQC_CODE_W-1:0] accept_code_i,
  // results
  output logic                       ref_pll_o,
  output logic                       qualified_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    rqc_qstate_t          st;
    logic [RQC_CNT_W-1:0] cnt;
    logic                 rx;
    logic                 half;
    logic                 out;
  } rqc_qual_t;

  rqc_qual_t            s_q, s_d;
  logic                 rx_c, rise_c, fail_c;
  logic [RQC_CNT_W-1:0] drop_cyc, acc_cyc;
  logic [34:0]          acc_full;

  // delay selection per code
  always_comb begin
    case (drop_code_i)
      2'h0:    drop_cyc = RQC_CNT_W'(RQC_DROP_MIN_CYC);
      2'h1:    drop_cyc = RQC_CNT_W'(DROP_10MS_CYC);
      2'h2:    drop_cyc = RQC_CNT_W'(DROP_50MS_CYC);
      default: drop_cyc = RQC_CNT_W'(DROP_2S5_CYC);
    endcase
    acc_full = {3'h0, drop_cyc} * 35'(4'({accept_code_i, 1'b0}) + 4'h2);
    acc_cyc  = acc_full[RQC_CNT_W-1:0];
  end

  // receiver, halving and qualify state machine
  always_comb begin
    rx_c   = diff_i ? (ref_p_i & ~ref_n_i) : ref_p_i;
    rise_c = rx_c & ~s_q.rx;
    fail_c = cfm_fail_i | scm_fail_i;
    s_d      = s_q;
    s_d.rx   = rx_c;
    s_d.half = s_q.half ^ rise_c;
    s_d.out  = halve_i ? (s_q.half ^ rise_c) : rx_c;
    case (s_q.st)
      RQC_ST_QUAL: begin
        if (fail_c) begin
          s_d.st  = RQC_ST_DROP;
          s_d.cnt = RQC_CNT_W'(1);
        end
      end
      RQC_ST_DROP: begin
        if (!fail_c) begin
          s_d.st = RQC_ST_QUAL;
        end else if (s_q.cnt >= drop_cyc) begin
          s_d.st = RQC_ST_DISQ;
        end else begin
          s_d.cnt = s_q.cnt + RQC_CNT_W'(1);
        end
      end
      RQC_ST_DISQ: begin
        if (!fail_c) begin
          s_d.st  = RQC_ST_ACC;
          s_d.cnt = RQC_CNT_W'(1);
        end
      end
      RQC_ST_ACC: begin
        if (fail_c) begin
          s_d.st = RQC_ST_DISQ;
        end else if (s_q.cnt >= acc_cyc) begin
          s_d.st = RQC_ST_QUAL;
        end else begin
          s_d.cnt = s_q.cnt + RQC_CNT_W'(1);
        end
      end
      default: s_d.st = RQC_ST_QUAL;
    endcase
  end

  // state register
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_q <= '{st: RQC_ST_QUAL, cnt: '0, rx: 1'b0, half: 1'b0, out: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign ref_pll_o   = s_q.out;
  assign qualified_o = (s_q.st == RQC_ST_QUAL) || (s_q.st == RQC_ST_DROP);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [RQC_CNT_W-1:0] fail_run_q, ok_run_q;

  // consecutive fail and clean cycle counts for the timer checks
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fail_run_q <= '0;
      ok_run_q   <= '0;
    end else begin
      fail_run_q <= fail_c ? fail_run_q + RQC_CNT_W'(1) : '0;
      ok_run_q   <= fail_c ? '0 : ok_run_q + RQC_CNT_W'(1);
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  a_pass_through: assert property (!halve_i |=> ref_pll_o == $past(rx_c))
    else $error("undivided path does not follow the receiver");
  // halving must have held for two cycles, so switching it on is not taken for a toggle
  a_halve_edge: assert property ($past(halve_i, 2) && $past(halve_i) && $changed(ref_pll_o)
                 |-> $past(rise_c))
    else $error("halved clock moved without a receiver rising edge");
  a_input_type: assert property (!diff_i |=> s_q.rx == $past(ref_p_i))
    else $error("single-ended reception does not follow the positive pin");
  a_drop_time: assert property ($fell(qualified_o) |-> fail_run_q == drop_cyc + RQC_CNT_W'(1))
    else $error("reference dropped after the wrong delay");
  a_accept_time: assert property ($rose(qualified_o) |-> ok_run_q == acc_cyc + RQC_CNT_W'(1))
    else $error("reference accepted after the wrong delay");
  a_accept_restart: assert property (s_q.st == RQC_ST_ACC && fail_c |=> !qualified_o [*2])
    else $error("flag during accept delay did not keep reference out");
  c_drop: cover property ($fell(qualified_o));
  c_accept: cover property ($rose(qualified_o));

endmodule
`default_nettype wire

/* verif/rqc_tb.sv */
// bench for the reference qualify configuration registers
// assumes rqc_pkg and rqc_config are compiled first; drives all ports itself
`default_nettype none
module testbench
  import rqc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // clock, reset and design ports
  // ----------------------------------------------------------------
  logic        clk_i    = 1'b0;
  logic        arst_n_i = 1'b0;
  rqc_req_t    req      = '0;
  logic [7:0]  rdata;
  logic [3:0]  p        = '0;
  logic [3:0]  n        = '0;
  logic [3:0]  cfm      = '0;
  logic [3:0]  scm      = '0;
  logic [3:0]  pll;
  logic [3:0]  qual;
  logic        sticky;
  logic [15:0] base;
  int          fails      = 0;
  int          n_compared = 0;
  int          rises [4];
  int          td [4];
  int          ta [4];
  int          t;
  logic [7:0]  rv;

  // short delays keep the qualify runs brief
  rqc_config #(
    .DROP_10MS_CYC (5),
    .DROP_50MS_CYC (10),
    .DROP_2S5_CYC  (20)
  ) i_rqc_config (
    .clk_i              (clk_i),
    .arst_n_i           (arst_n_i),
    .reg_req_i          (req),
    .reg_rdata_o        (rdata),
    .ref_p_i            (p),
    .ref_n_i            (n),
    .cfm_fail_i         (cfm),
    .scm_fail_i         (scm),
    .ref_pll_o          (pll),
    .ref_qualified_o    (qual),
    .sticky_update_en_o (sticky),
    .base_rate_hz_o     (base)
  );

  // 25 MHz clock
  always #20 clk_i = ~clk_i;

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one-cycle write strobe, released at the next falling edge
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk_i);
    req = '0;
  endtask

  // two writes on back-to-back edges, high byte at the lower address first
  task automatic wr_pair(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk_i);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d[15:8]};
    @(negedge clk_i);
    req = '{wr: 1'b1, rd: 1'b0, addr: a + 8'h01, wdata: d[7:0]};
    @(negedge clk_i);
    req = '0;
  endtask

  // read data is taken once it has settled after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_i);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk_i);
    req = '0;
    @(negedge clk_i);
    d = rdata;
  endtask

  // odd references fail through the single cycle flag, even through coarse frequency
  task automatic fail_set(input int r, input logic v);
    if (r % 2) scm[r] = v;
    else cfm[r] = v;
  endtask

  // counts falling edges until a qualified output reaches the level
  task automatic wait_q(input int r, input logic lvl, output int cnt);
    cnt = 0;
    while (qual[r] !== lvl && cnt < 1000) begin
      @(negedge clk_i);
      cnt++;
    end
  endtask

  // eight input periods of four cycles on every positive pin, output rises counted
  task automatic wave(input logic [7:0] setup, input logic [3:0] nv);
    logic [3:0] prev;
    wr_reg(RQC_ADDR_SETUP, setup);
    n = nv;
    prev = pll;
    rises = '{default: 0};
    for (int c = 0; c < 40; c++) begin
      @(negedge clk_i);
      p = (c < 32 && c[1]) ? 4'hf : 4'h0;
      for (int r = 0; r < 4; r++) if (pll[r] === 1'b1 && prev[r] === 1'b0) rises[r]++;
      prev = pll;
    end
  endtask

  // fail one reference, then clear it, timing both moves
  task automatic measure(input int r);
    @(negedge clk_i);
    fail_set(r, 1'b1);
    wait_q(r, 1'b0, td[r]);
    @(negedge clk_i);
    fail_set(r, 1'b0);
    wait_q(r, 1'b1, ta[r]);
  endtask

  task automatic summarize;
    $display("compared %0d mismatched %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    logic [7:0]  ra [9];
    logic [7:0]  re [9];
    logic [15:0] bv [5];
    logic [7:0]  ws [5];
    logic [3:0]  wn [5];
    logic [15:0] we [5];
    int          dd [4];
    ra = '{8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h10, 8'h11, 8'h0f, 8'h20};
    re = '{8'h10, 8'haa, 8'h55, 8'h00, 8'h0f, 8'h9c, 8'h40, 8'h00, 8'h00};
    bv = '{16'h1f40, 16'h3e80, 16'h61a8, 16'h9c40, 16'h1234};
    ws = '{8'h00, 8'hf0, 8'hf0, 8'h5a, 8'h0f};
    wn = '{4'hf, 4'hf, 4'h0, 4'hf, 4'h0};
    we = '{16'h8888, 16'h0000, 16'h8888, 16'h4040, 16'h4444};
    dd = '{1, 5, 10, 20};
    repeat (16) @(negedge clk_i);
    arst_n_i = 1'b1;
    // reset values; writes to the status and an unmapped place are dropped
    chk("qualified", 16'h000f, {12'h000, qual});
    chk("sticky enable", 16'h0001, {15'h0000, sticky});
    chk("base rate", RQC_RST_BASE, base);
    wr_reg(8'h0e, 8'h00);
    wr_reg(8'h20, 8'hff);
    for (int i = 0; i < 9; i++) begin
      rd_reg(ra[i], rv);
      chk("register read", {8'h00, re[i]}, {8'h00, rv});
    end
    $display("test reset done");
    // receiver type and halving per reference
    for (int i = 0; i < 5; i++) begin
      wave(ws[i], wn[i]);
      for (int r = 0; r < 4; r++) chk("pll rises", 16'(we[i][4*r +: 4]), 16'(rises[r]));
    end
    $display("test receiver done");
    // drop delay codes 0..3 on references 0..3, shortest accept
    wr_reg(RQC_ADDR_DROP, 8'he4);
    wr_reg(RQC_ADDR_ACCEPT, 8'h00);
    for (int r = 0; r < 4; r++) measure(r);
    chk("drop time", 16'(dd[0] + 1), 16'(td[0]));
    chk("accept time", 16'(2 * dd[0] + 1), 16'(ta[0]));
    for (int r = 1; r < 4; r++) begin
      chk("drop time", 16'(dd[r] - 1), 16'(td[r] - td[0]));
      chk("accept time", 16'(2 * dd[r] - 2), 16'(ta[r] - ta[0]));
    end
    // accept codes 0..3 on references 0..3, shortest drop
    wr_reg(RQC_ADDR_DROP, 8'h00);
    wr_reg(RQC_ADDR_ACCEPT, 8'he4);
    for (int r = 0; r < 4; r++) measure(r);
    for (int r = 1; r < 4; r++) chk("accept code", 16'(2 * r), 16'(ta[r] - ta[0]));
    // flag returns mid accept delay: reference stays out and the delay restarts
    @(negedge clk_i);
    fail_set(3, 1'b1);
    wait_q(3, 1'b0, t);
    @(negedge clk_i);
    fail_set(3, 1'b0);
    repeat (4) @(negedge clk_i);
    fail_set(3, 1'b1);
    @(negedge clk_i);
    fail_set(3, 1'b0);
    chk("held out", 16'h0000, {15'h0000, qual[3]});
    wait_q(3, 1'b1, t);
    chk("restarted accept", 16'(ta[3]), 16'(t));
    $display("test qualify done");
    // freeze and resume of sticky status updates
    wr_reg(RQC_ADDR_LOCK, RQC_LOCK_ON);
    chk("frozen", 16'h0000, {15'h0000, sticky});
    rd_reg(RQC_ADDR_STATUS, rv);
    chk("status frozen", 16'h001f, {8'h00, rv});
    wr_reg(RQC_ADDR_LOCK, RQC_LOCK_OFF);
    chk("resumed", 16'h0001, {15'h0000, sticky});
    rd_reg(RQC_ADDR_LOCK, rv);
    chk("lock read", 16'h0000, {8'h00, rv});
    $display("test lock done");
    // base rate: high byte first at the lower address, legal codes then one illegal
    for (int i = 0; i < 5; i++) begin
      if (i % 2) begin
        wr_reg(RQC_ADDR_BASE_HI, bv[i][15:8]);
        wr_reg(RQC_ADDR_BASE_LO, bv[i][7:0]);
      end else begin
        wr_pair(RQC_ADDR_BASE_HI, bv[i]);
      end
      chk("effective rate", (i == 4) ? RQC_BASE_8K : bv[i], base);
      rd_reg(RQC_ADDR_BASE_HI, rv);
      chk("base high", {8'h00, bv[i][15:8]}, {8'h00, rv});
      rd_reg(RQC_ADDR_BASE_LO, rv);
      chk("base low", {8'h00, bv[i][7:0]}, {8'h00, rv});
    end
    $display("test base rate done");
    summarize();
  end

  // cuts a hang short well past the expected run length
  initial begin
    #(40 * 30000);
    fails++;
    summarize();
  end

endmodule
`default_nettype wire
